// [common/dsm_pkg.sv]
// package of constants and types for the serial mode-control block
package dsm_pkg;
    localparam int WORD_BITS = 16;
    localparam int MODE_BITS = 2;
    localparam int RES_BITS  = 12;
    localparam int CNT_BITS  = 5;
    localparam logic [4:0] LAST_BIT_CNT = 5'h0F;
    localparam logic [RES_BITS-1:0] CODE_RESET = 12'h000;
    // wake-up delay, in nanoseconds
    localparam int WAKE_5V_NS = 13000;
    localparam int WAKE_3V_NS = 16000;
    localparam int MCLK_MHZ   = 40;
    localparam int WAKE_5V_CYC = (WAKE_5V_NS * MCLK_MHZ + 999) / 1000;
    localparam int WAKE_3V_CYC = (WAKE_3V_NS * MCLK_MHZ + 999) / 1000;
    localparam int WAKE_CNT_BITS = 10;

    typedef enum logic [1:0] {
        DSM_MODE_NORMAL = 2'b00,
        DSM_MODE_PD_1K  = 2'b01,
        DSM_MODE_PD_100K = 2'b10,
        DSM_MODE_PD_HIZ = 2'b11
    } dsm_mode_t;

    typedef enum logic [1:0] {
        DSM_ST_RUN   = 2'b00,
        DSM_ST_DOWN  = 2'b01,
        DSM_ST_WAKE  = 2'b10
    } dsm_state_t;
endpackage

// [core/dsm_dac_ctrl.sv]
// serial word receiver and mode/code control for the converter
`timescale 1ns/1ps
module dsm_dac_ctrl
    import dsm_pkg::*;
#(
    parameter int RES        = dsm_pkg::RES_BITS,
    parameter int WAKE_5V    = dsm_pkg::WAKE_5V_CYC,
    parameter int WAKE_3V    = dsm_pkg::WAKE_3V_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire logic                 serialClk,
    input  wire logic                 frameSel_b,
    input  wire logic                 serial_data_in,
    input  wire logic                 supplyLow,
    output logic [RES-1:0]            dacCode,
    output dsm_pkg::dsm_mode_t        opMode,
    output logic                      ampEnable,
    output logic                      termOneK,
    output logic                      termHundredK,
    output logic                      outputValid,
    output logic                      outputZero
);
    import dsm_pkg::*;

    // ************************************************************
    // link domain: shifter on falling serial clock
    // ************************************************************
    logic [WORD_BITS-1:0] shift_q, shift_d;
    logic [CNT_BITS-1:0]  cnt_q, cnt_d;
    logic [WORD_BITS-1:0] word_q, word_d;
    logic                 tog_q, tog_d;

    always_comb begin
        shift_d = {shift_q[WORD_BITS-2:0], serial_data_in};
        cnt_d   = cnt_q;
        word_d  = word_q;
        tog_d   = tog_q;
        if (cnt_q < 5'(WORD_BITS)) begin
            cnt_d = cnt_q + 5'h01;
        end
        if (cnt_q == LAST_BIT_CNT) begin
            word_d = shift_d;
            tog_d  = ~tog_q;
        end
    end

    // frame select high holds the shifter in reset, so an early rise drops the word
    always_ff @(negedge serialClk or posedge frameSel_b) begin
        if (frameSel_b) begin
            shift_q <= '0;
            cnt_q   <= '0;
        end else begin
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
        end
    end

    // word and toggle survive frames; only power-on clears them
    always_ff @(negedge serialClk or negedge rst_b) begin
        if (!rst_b) begin
            word_q <= '0;
            tog_q  <= 1'b0;
        end else begin
            word_q <= word_d;
            tog_q  <= tog_d;
        end
    end

    // ************************************************************
    // crossing: toggle event, word stable across it
    // ************************************************************
    logic togSync;
    logic supplyLowSync;

    dsm_sync3 #(.RESET_VAL(1'b0)) u_sync_tog (
        .clk     (mclk),
        .rst_b   (rst_b),
        .asyncIn (tog_q),
        .syncOut (togSync)
    );

    dsm_sync3 #(.RESET_VAL(1'b0)) u_sync_supply (
        .clk     (mclk),
        .rst_b   (rst_b),
        .asyncIn (supplyLow),
        .syncOut (supplyLowSync)
    );

    // ************************************************************
    // core domain: mode, code and wake-up
    // ************************************************************
    logic                     togSeen_q, togSeen_d;
    logic [RES-1:0]           code_q, code_d;
    dsm_mode_t                mode_q, mode_d;
    dsm_state_t               state_q, state_d;
    logic [WAKE_CNT_BITS-1:0] wake_q, wake_d;
    logic                     written_q, written_d;
    logic                     amp_q, amp_d, t1k_q, t1k_d, t100k_q, t100k_d;
    logic                     valid_q, valid_d, zero_q, zero_d;
    logic                     wordNew;
    dsm_mode_t                newMode;

    always_comb begin
        wordNew   = togSync != togSeen_q;
        newMode   = dsm_mode_t'(word_q[WORD_BITS-1 -: MODE_BITS]);
        togSeen_d = togSync;
        code_d    = code_q;
        mode_d    = mode_q;
        written_d = written_q;
        state_d   = state_q;
        wake_d    = wake_q;
        if (wordNew) begin
            // word_q held still since toggle flipped four mclk edges before
            code_d    = word_q[WORD_BITS-1-MODE_BITS -: RES];
            mode_d    = newMode;
            written_d = 1'b1;
        end
        unique case (state_q)
            DSM_ST_RUN: begin
                if (wordNew && newMode != DSM_MODE_NORMAL) begin
                    state_d = DSM_ST_DOWN;
                end
            end
            DSM_ST_DOWN: begin
                if (wordNew && newMode == DSM_MODE_NORMAL) begin
                    state_d = DSM_ST_WAKE;
                    wake_d  = supplyLowSync ? WAKE_CNT_BITS'(WAKE_3V - 1)
                                            : WAKE_CNT_BITS'(WAKE_5V - 1);
                end
            end
            DSM_ST_WAKE: begin
                if (wordNew && newMode != DSM_MODE_NORMAL) begin
                    state_d = DSM_ST_DOWN;
                end else if (wake_q == '0) begin
                    state_d = DSM_ST_RUN;
                end else begin
                    wake_d = wake_q - 1'b1;
                end
            end
            default: state_d = DSM_ST_DOWN;
        endcase
        // outputs follow next state so they leave flops aligned with it
        amp_d   = state_d != DSM_ST_DOWN;
        t1k_d   = state_d == DSM_ST_DOWN && mode_d == DSM_MODE_PD_1K;
        t100k_d = state_d == DSM_ST_DOWN && mode_d == DSM_MODE_PD_100K;
        valid_d = state_d == DSM_ST_RUN;
        zero_d  = !written_d;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            togSeen_q <= 1'b0;
            code_q    <= CODE_RESET[RES-1:0];
            mode_q    <= DSM_MODE_NORMAL;
            state_q   <= DSM_ST_RUN;
            wake_q    <= '0;
            written_q <= 1'b0;
            amp_q     <= 1'b1;
            t1k_q     <= 1'b0;
            t100k_q   <= 1'b0;
            valid_q   <= 1'b1;
            zero_q    <= 1'b1;
        end else begin
            togSeen_q <= togSeen_d;
            code_q    <= code_d;
            mode_q    <= mode_d;
            state_q   <= state_d;
            wake_q    <= wake_d;
            written_q <= written_d;
            amp_q     <= amp_d;
            t1k_q     <= t1k_d;
            t100k_q   <= t100k_d;
            valid_q   <= valid_d;
            zero_q    <= zero_d;
        end
    end

    assign dacCode      = code_q;
    assign opMode       = mode_q;
    assign ampEnable    = amp_q;
    assign termOneK     = t1k_q;
    assign termHundredK = t100k_q;
    assign outputValid  = valid_q;
    assign outputZero   = zero_q;
endmodule

// [core/dsm_sync3.sv]
// three-stage synchroniser with agreement filter for one level
`timescale 1ns/1ps
module dsm_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic s1_q, s2_q, s3_q, out_q;
    logic out_d;

    always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q  <= RESET_VAL;
            s2_q  <= RESET_VAL;
            s3_q  <= RESET_VAL;
            out_q <= RESET_VAL;
        end else begin
            s1_q  <= asyncIn;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign syncOut = out_q;
endmodule

// [tb/dsm_dac_ctrl_props.sv]
// checker: port assertions for the converter mode and code control
`timescale 1ns/1ps
module dsm_dac_ctrl_props
    import dsm_pkg::*;
#(
    parameter int RES = RES_BITS
) (
    input wire logic           mclk,
    input wire logic           rst_b,
    input wire dsm_mode_t      opMode,
    input wire logic [RES-1:0] dacCode,
    input wire logic           ampEnable,
    input wire logic           termOneK,
    input wire logic           termHundredK,
    input wire logic           outputValid,
    input wire logic           outputZero
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    norm_drive_a: assert property (opMode == DSM_MODE_NORMAL |-> ampEnable && !termOneK && !termHundredK)
        else $error("normal mode drive wrong");
    one_k_a: assert property (opMode == DSM_MODE_PD_1K |-> termOneK && !ampEnable && !termHundredK)
        else $error("1k termination wrong");
    hundred_k_a: assert property (opMode == DSM_MODE_PD_100K |-> termHundredK && !ampEnable && !termOneK)
        else $error("100k termination wrong");
    hiz_out_a: assert property (opMode == DSM_MODE_PD_HIZ |-> !(termHundredK || ampEnable || termOneK))
        else $error("high-z output driven");
    down_invalid_a: assert property (opMode != DSM_MODE_NORMAL |-> !outputValid)
        else $error("valid while powered down");
    wake_delay_a: assert property ($changed(opMode) && opMode == DSM_MODE_NORMAL
        |-> !outputValid [*6] ##[1:8] outputValid) else $error("wake-up delay wrong");
    zero_code_a: assert property (outputZero |-> dacCode == '0 && opMode == DSM_MODE_NORMAL)
        else $error("zero flag with code loaded");
    code_flag_a: assert property ($changed(dacCode) |-> !outputZero)
        else $error("zero flag kept after load");
    cover property (opMode == DSM_MODE_PD_HIZ);
    cover property ($rose(outputValid));
    cover property ($fell(outputZero));
endmodule
bind dsm_dac_ctrl dsm_dac_ctrl_props #(.RES(RES)) i_dsm_dac_ctrl_props (.mclk(mclk), .rst_b(rst_b),
    .opMode(opMode), .dacCode(dacCode), .ampEnable(ampEnable), .termOneK(termOneK),
    .termHundredK(termHundredK), .outputValid(outputValid), .outputZero(outputZero));

// [tb/dsm_host_model.sv]
// host serial port model: framed words, clock parked low between frames
`timescale 1ns/1ps
module dsm_host_model (
    output logic serialClk,
    output logic frameSel_b,
    output logic serialData
);
    initial begin
        serialClk = 1'b0;
        frameSel_b = 1'b1;
        serialData = 1'b0;
    end
    // nBits below 16 aborts the frame early
    task automatic send(input logic [15:0] w, input int nBits, input bit split);
        #3.3 frameSel_b = 1'b0;
        #7.5;
        for (int i = 15; i > 15 - nBits; i--) begin
            serialClk = 1'b1;
            serialData = w[i];
            #7.5 serialClk = 1'b0;
            #7.5;
            if (split && i == 8) #40;
        end
        #7.5 frameSel_b = 1'b1;
        serialData = ~serialData; // line driven to the inverse of the last bit: no stale bit
        #30;
    endtask
endmodule

// [tb/tb.sv]
// testbench: corner and random words through the converter control
`timescale 1ns/1ps
module tb;
    import dsm_pkg::*;
    logic                mclk, rst_b, supplyLow, serialClk, frameSel_b, serialData;
    logic [RES_BITS-1:0] dacCode;
    dsm_mode_t           opMode;
    logic                ampEnable, termOneK, termHundredK, outputValid, outputZero;
    int                  fails = 0, comparisons = 0;
    bit                  wasDown = 0;
    logic [15:0]         rnd = 16'h0017;
    logic [15:0]         corner [5] = '{16'h3FFC, 16'h5555, 16'h0004, 16'hAAA8, 16'hC003};
    // wake counts shortened but kept at or above the response wait, so the low phase is still seen
    dsm_dac_ctrl #(.WAKE_5V(12), .WAKE_3V(13)) i_dsm_dac_ctrl (.mclk(mclk), .rst_b(rst_b), .serialClk(serialClk),
        .frameSel_b(frameSel_b), .serial_data_in(serialData), .supplyLow(supplyLow), .dacCode(dacCode),
        .opMode(opMode), .ampEnable(ampEnable), .termOneK(termOneK), .termHundredK(termHundredK),
        .outputValid(outputValid), .outputZero(outputZero));
    dsm_host_model i_dsm_host_model (.serialClk(serialClk), .frameSel_b(frameSel_b), .serialData(serialData));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] expDrive(logic [1:0] m);
        return 32'({m == 2'b00, m == 2'b01, m == 2'b10, 1'b0});
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic put(logic [15:0] w, int n, bit split);
        @(negedge mclk);
        supplyLow <= rnd[2];
        i_dsm_host_model.send(w, n, split);
        repeat (12) @(negedge mclk);
    endtask
    task automatic wordCheck(logic [15:0] w);
        check(32'(opMode), 32'(w[15:14]));
        check(32'(dacCode), 32'(w[13 -: RES_BITS]));
        check(32'({ampEnable, termOneK, termHundredK, outputZero}), expDrive(w[15:14]));
        if (w[15:14] != 2'b00) check(32'(outputValid), 32'h0);
        else if (wasDown) begin
            check(32'(outputValid), 32'h0);
            repeat (16) @(negedge mclk);
            check(32'(outputValid), 32'h1);
        end else check(32'(outputValid), 32'h1);
        wasDown = (w[15:14] != 2'b00);
    endtask
    initial begin
        rst_b = 1'b0;
        supplyLow = 1'b0;
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        check(32'({dacCode, opMode, ampEnable, outputValid, outputZero}), 32'h7);
        put(16'hFFFC, 10, 1'b0);
        check(32'({dacCode, opMode, ampEnable, outputValid, outputZero}), 32'h7);
        foreach (corner[i]) begin
            put(corner[i], 16, 1'(i % 2));
            wordCheck(corner[i]);
        end
        put(16'h3FFC, 15, 1'b1);
        check(32'({dacCode, opMode}), 32'h3);
        repeat (12) begin
            rnd = lfsr(rnd);
            put(rnd, 16, rnd[1]);
            wordCheck(rnd);
        end
        conclude();
    end
    initial begin
        repeat (8000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule
